//--- verilog/srtu_pkg.sv
// Purpose: shared constants for the scheduled run timer unit
// Assumes: time of day counted in minutes, weekday 0 = Monday .. 6 = Sunday
// Notes:   register offsets are byte addresses on the AHB-Lite slave

package srtu_pkg;

	// ==========================================================
	// Sizes
	localparam int SRTU_NT    = 4;             // Number of timers
	localparam int SRTU_MIN_W = 11;            // Minutes 0..1440
	localparam int SRTU_DAY_W = 4;             // Day selection code
	localparam int SRTU_ACT_W = 2;             // Action code
	localparam int SRTU_REF_W = 3;             // Reference source code
	localparam int SRTU_WD_W  = 3;             // Weekday number
	localparam int SRTU_NIN   = 5;             // Synchronised pins

	// ==========================================================
	// Register map
	localparam logic [7:0] SRTU_OFF_CFG0   = 8'h00; // Timer n at 0x00 + 4*n
	localparam logic [7:0] SRTU_OFF_STATUS = 8'h10;
	localparam logic [31:0] SRTU_CFG_RST   = 32'h0000_0000;
	localparam logic [31:0] SRTU_CFG_MASK  = 32'h7FFF_FFFF;

	// Fields of a timer configuration word
	localparam int SRTU_F_START = 0;
	localparam int SRTU_F_STOP  = 11;
	localparam int SRTU_F_DAY   = 22;
	localparam int SRTU_F_ACT   = 26;
	localparam int SRTU_F_REF   = 28;

	// Fields of the status word
	localparam int SRTU_S_ACTIVE = 0;
	localparam int SRTU_S_CANCEL = 4;
	localparam int SRTU_S_RUN    = 8;
	localparam int SRTU_S_OFF    = 9;
	localparam int SRTU_S_REF    = 10;
	localparam int SRTU_S_PI     = 13;
	localparam int SRTU_S_WIN    = 14;

	// ==========================================================
	// Codes
	localparam logic [SRTU_MIN_W-1:0] SRTU_MIDNIGHT = 11'h5A0; // 24:00
	localparam logic [SRTU_ACT_W-1:0] SRTU_ACT_STATUS = 2'h0;
	localparam logic [SRTU_ACT_W-1:0] SRTU_ACT_RUN    = 2'h1;
	localparam logic [SRTU_ACT_W-1:0] SRTU_ACT_RUN_NOPI = 2'h2;
	localparam logic [SRTU_DAY_W-1:0] SRTU_DAY_OFF   = 4'h0;
	localparam logic [SRTU_DAY_W-1:0] SRTU_DAY_DAILY = 4'h1;
	localparam logic [SRTU_DAY_W-1:0] SRTU_DAY_WORK  = 4'h2;
	localparam logic [SRTU_DAY_W-1:0] SRTU_DAY_WEND  = 4'h3;
	localparam logic [SRTU_DAY_W-1:0] SRTU_DAY_MON   = 4'h4;
	localparam logic [SRTU_DAY_W-1:0] SRTU_DAY_SUN   = 4'hA;
	localparam logic [SRTU_WD_W-1:0]  SRTU_WD_MON    = 3'h0;
	localparam logic [SRTU_WD_W-1:0]  SRTU_WD_FRI    = 3'h4;
	localparam logic [SRTU_WD_W-1:0]  SRTU_WD_SAT    = 3'h5;
	localparam logic [SRTU_WD_W-1:0]  SRTU_WD_SUN    = 3'h6;

	// Pin order inside the synchroniser bundle
	localparam int SRTU_P_RUN = 0;
	localparam int SRTU_P_JF  = 1;
	localparam int SRTU_P_JR  = 2;
	localparam int SRTU_P_DIS = 3;
	localparam int SRTU_P_CAN = 4;

	localparam logic [1:0] SRTU_HRESP_OKAY = 2'h0;

endpackage

//--- verilog/srtu_sync.sv
// Purpose: two flip-flop synchroniser for terminal inputs
// Assumes: inputs are slow levels from pins
// Notes:   first stage is read only by the second stage

`timescale 1ns/1ps
`default_nettype none

module srtu_sync
#(
	parameter int W = 1
)
(
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin_in,
	output var  logic [W-1:0] pin_sync
);

	// ==========================================================
	// One stage pair per bit
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1)
		begin : g_bit
			logic meta_r;
			always_ff @(posedge sys_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_r      <= 1'b0;
					pin_sync[g] <= 1'b0;
				end
				else
				begin
					meta_r      <= pin_in[g];
					pin_sync[g] <= meta_r;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

//--- verilog/srtu_window.sv
// Purpose: decide whether one timer's schedule covers the present minute
// Assumes: start <= stop, both within 00:00 .. 24:00
// Notes:   purely combinational; the caller samples it on each update

`timescale 1ns/1ps
`default_nettype none

module srtu_window
	import srtu_pkg::*;
(
	input  wire logic [srtu_pkg::SRTU_MIN_W-1:0] start_min,
	input  wire logic [srtu_pkg::SRTU_MIN_W-1:0] stop_min,
	input  wire logic [srtu_pkg::SRTU_DAY_W-1:0] day_sel,
	input  wire logic [srtu_pkg::SRTU_WD_W-1:0]  wday,
	input  wire logic [srtu_pkg::SRTU_MIN_W-1:0] now_min,
	output logic                                 in_window
);

	// ==========================================================
	// Day decode: single day codes follow Monday onward
	wire logic is_single = (day_sel >= SRTU_DAY_MON) && (day_sel <= SRTU_DAY_SUN);
	wire logic [SRTU_WD_W-1:0] single_wd = SRTU_WD_W'(day_sel - SRTU_DAY_MON);
	wire logic is_work  = (day_sel == SRTU_DAY_WORK);
	wire logic is_wend  = (day_sel == SRTU_DAY_WEND);
	wire logic is_daily = (day_sel == SRTU_DAY_DAILY);
	wire logic day_hit  = is_daily
		|| (is_work && (wday <= SRTU_WD_FRI))
		|| (is_wend && (wday >= SRTU_WD_SAT))
		|| (is_single && (wday == single_wd));    // see [RULE_15]

	// Span of a multi-day block for the equal start/stop case
	wire logic [SRTU_WD_W-1:0] first_wd = is_work ? SRTU_WD_MON : SRTU_WD_SAT;
	wire logic [SRTU_WD_W-1:0] last_wd  = is_work ? SRTU_WD_FRI : SRTU_WD_SUN;

	// Normal window is start inclusive, stop exclusive; 24:00 never reached
	wire logic after_start = (now_min >= start_min);              // see [RULE_01]
	wire logic before_stop = (now_min < stop_min);                // see [RULE_02] [RULE_11]
	wire logic equal_mode  = (start_min == stop_min);

	// Continuous block across days when start equals stop
	wire logic span_hit = ((wday == first_wd) && after_start)
		|| ((wday > first_wd) && (wday < last_wd))
		|| ((wday == last_wd) && !after_start);                   // see [RULE_09]

	// Single day or daily runs from the set time until 24:00
	wire logic to_midnight = day_hit && after_start;             // see [RULE_10]

	assign in_window = !equal_mode ? (day_hit && after_start && before_stop)
		: (is_work || is_wend) ? span_hit
		: to_midnight;                                            // see [RULE_20]

endmodule

`default_nettype wire

//--- verilog/srtu_top.sv
// Purpose: four calendar driven run timers gating the drive run command
// Assumes: clock time, weekday and minute strobe come from logic on sys_clk
// Notes:   registers reached over AHB-Lite, zero wait states, always OKAY
//
// Behaviour
// [RULE_01] Start action at start time on selected day
// [RULE_02] Stop action when stop time is reached
// [RULE_03] Action 0 or disable input: no gating
// [RULE_04] Actions 1/2 gate run, select timer reference
// [RULE_05] Action 2 disables PI while active
// [RULE_06] Cancel edge disables active timer until next
// [RULE_07] Run command cycle re-enables cancelled timer
// [RULE_08] Status output follows active timer, any action
// [RULE_09] Equal times: continuous across selected day block
// [RULE_10] Equal times, one day or daily: until 24:00
// [RULE_11] 24:00 means midnight starting next day
// [RULE_12] Lowest numbered active timer wins
// [RULE_13] Jog commands override every timer
// [RULE_14] Software keeps times in range, start <= stop
// [RULE_15] Day code 0..10 decoded to day sets
// [RULE_16] Timers 2 to 4 identical and independent
// [RULE_17] Run, gating, no active timer: show timers off
// [RULE_18] Action code 0..2: status, run, run without PI
// [RULE_19] Reference code 0..6 selects reference source
// [RULE_20] Evaluate each minute update, stop exclusive
// [RULE_21] Recompute on power up and clock set
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.

`timescale 1ns/1ps
`default_nettype none

module srtu_top
	import srtu_pkg::*;
(
	input  wire logic                              sys_clk,
	input  wire logic                              rst_n,
	// AHB-Lite slave
	input  wire logic                              hsel,
	input  wire logic [31:0]                       haddr,
	input  wire logic [1:0]                        htrans,
	input  wire logic                              hwrite,
	input  wire logic [2:0]                        hsize,
	input  wire logic [31:0]                       hwdata,
	input  wire logic                              hready,
	output logic                                   hreadyout,
	output logic                                   hresp,
	output logic [31:0]                            hrdata,
	// Real-time clock, same clock domain
	input  wire logic [srtu_pkg::SRTU_MIN_W-1:0]   rtc_minute,
	input  wire logic [srtu_pkg::SRTU_WD_W-1:0]    rtc_weekday,
	input  wire logic                              rtc_tick,
	input  wire logic                              rtc_set,
	// Terminal and sequencer pins
	input  wire logic                              run_cmd_in,
	input  wire logic                              jog_fwd_in,
	input  wire logic                              jog_rev_in,
	input  wire logic                              timer_disable_in,
	input  wire logic                              timer_cancel_in,
	// Results to the run sequencer and outputs
	output logic [srtu_pkg::SRTU_NT-1:0]           timer_status_out,
	output logic                                   run_enable_out,
	output logic                                   ref_override_out,
	output logic [srtu_pkg::SRTU_REF_W-1:0]        ref_source_out,
	output logic                                   pi_disable_out,
	output logic                                   timers_off_out
);

	// ==========================================================
	// Pin synchronisation
	logic [SRTU_NIN-1:0] pins_raw;
	logic [SRTU_NIN-1:0] pins_s;

	assign pins_raw[SRTU_P_RUN] = run_cmd_in;
	assign pins_raw[SRTU_P_JF]  = jog_fwd_in;
	assign pins_raw[SRTU_P_JR]  = jog_rev_in;
	assign pins_raw[SRTU_P_DIS] = timer_disable_in;
	assign pins_raw[SRTU_P_CAN] = timer_cancel_in;

	srtu_sync #(.W(SRTU_NIN)) u_sync
	(
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.pin_in   (pins_raw),
		.pin_sync (pins_s)
	);

	wire logic run_s    = pins_s[SRTU_P_RUN];
	wire logic jog_s    = pins_s[SRTU_P_JF] | pins_s[SRTU_P_JR];
	wire logic dis_s    = pins_s[SRTU_P_DIS];
	wire logic cancel_s = pins_s[SRTU_P_CAN];

	// Previous levels for edge detection, taken after the synchroniser
	logic run_q_r;
	logic cancel_q_r;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_q_r    <= 1'b0;
			cancel_q_r <= 1'b0;
		end
		else
		begin
			run_q_r    <= run_s;
			cancel_q_r <= cancel_s;
		end
	end

	wire logic run_rise    = run_s & ~run_q_r;               // see [RULE_07]
	wire logic cancel_rise = cancel_s & ~cancel_q_r;         // see [RULE_06]

	// ==========================================================
	// AHB-Lite address phase capture
	logic       wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] hrdata_r;

	wire logic ap_valid = hsel & htrans[1] & hready;
	wire logic ap_write = ap_valid & hwrite;
	wire logic ap_read  = ap_valid & ~hwrite;
	wire logic [7:0] ap_addr = haddr[7:0];
	wire logic ap_upper = |haddr[31:8];

	// Pending write lands at the end of its data phase
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= SRTU_OFF_CFG0;
		end
		else if (hready)
		begin
			wr_pend_r <= ap_write & ~ap_upper;
			wr_addr_r <= ap_addr;
		end
	end

	// ==========================================================
	// Timer configuration registers, one word per timer
	logic [31:0] cfg_r [SRTU_NT];
	logic [SRTU_NT-1:0] active_r;
	logic [SRTU_NT-1:0] cancel_r;
	logic [SRTU_NT-1:0] win_now;
	logic [SRTU_NT-1:0] cfg_wsel;
	logic [SRTU_NT-1:0] cfg_rsel;
	logic [SRTU_NT-1:0] gating;      // Timer has a run action and is allowed

	// Evaluation strobe: minute update, clock set, or first cycle out of reset
	logic init_r;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			init_r <= 1'b1;
		else
			init_r <= 1'b0;
	end

	wire logic eval_en = rtc_tick | rtc_set | init_r;      // see [RULE_20] [RULE_21]

	genvar t;
	generate
		for (t = 0; t < SRTU_NT; t = t + 1)
		begin : g_tmr
			// Field views of this timer's word
			wire logic [SRTU_MIN_W-1:0] f_start = cfg_r[t][SRTU_F_START +: SRTU_MIN_W];
			wire logic [SRTU_MIN_W-1:0] f_stop  = cfg_r[t][SRTU_F_STOP +: SRTU_MIN_W];
			wire logic [SRTU_DAY_W-1:0] f_day   = cfg_r[t][SRTU_F_DAY +: SRTU_DAY_W];
			wire logic [SRTU_ACT_W-1:0] f_act   = cfg_r[t][SRTU_F_ACT +: SRTU_ACT_W];

			assign cfg_wsel[t] = wr_pend_r && (wr_addr_r == 8'(SRTU_OFF_CFG0 + 4 * t));
			assign cfg_rsel[t] = (ap_addr == 8'(SRTU_OFF_CFG0 + 4 * t)) && !ap_upper;

			// Software keeps times in range; no clamping here
			always_ff @(posedge sys_clk or negedge rst_n)
			begin
				if (!rst_n)
					cfg_r[t] <= SRTU_CFG_RST;
				else if (cfg_wsel[t])
					cfg_r[t] <= hwdata & SRTU_CFG_MASK;      // see [RULE_14] [RULE_16]
			end

			srtu_window u_win
			(
				.start_min (f_start),
				.stop_min  (f_stop),
				.day_sel   (f_day),
				.wday      (rtc_weekday),
				.now_min   (rtc_minute),
				.in_window (win_now[t])
			);

			// Active state sampled only on an evaluation strobe
			always_ff @(posedge sys_clk or negedge rst_n)
			begin
				if (!rst_n)
					active_r[t] <= 1'b0;
				else if (eval_en)
					active_r[t] <= win_now[t];               // see [RULE_01] [RULE_02]
			end

			// Cancel: set wins over clear; cleared by run recycle or end of interval
			always_ff @(posedge sys_clk or negedge rst_n)
			begin
				if (!rst_n)
					cancel_r[t] <= 1'b0;
				else if (cancel_rise && active_r[t])
					cancel_r[t] <= 1'b1;                     // see [RULE_06]
				else if (run_rise || (eval_en && !win_now[t]))
					cancel_r[t] <= 1'b0;                     // see [RULE_07]
			end

			// Action 0 or the disable input leaves run untouched
			assign gating[t] = (f_act != SRTU_ACT_STATUS) && !dis_s; // see [RULE_03] [RULE_18]
		end
	endgenerate

	// ==========================================================
	// Priority among live timers, lowest number first
	wire logic [SRTU_NT-1:0] live = active_r & ~cancel_r & gating;

	logic                   win_any;
	logic [SRTU_ACT_W-1:0]  win_act;
	logic [SRTU_REF_W-1:0]  win_ref;

	// Scan downward so the lowest numbered live timer wins
	always_comb
	begin
		win_any = 1'b0;
		win_act = SRTU_ACT_STATUS;
		win_ref = '0;
		for (int i = SRTU_NT - 1; i >= 0; i--)
		begin
			if (live[i])
			begin
				win_any = 1'b1;
				win_act = cfg_r[i][SRTU_F_ACT +: SRTU_ACT_W];
				win_ref = cfg_r[i][SRTU_F_REF +: SRTU_REF_W]; // see [RULE_12] [RULE_19]
			end
		end
	end

	// ==========================================================
	// Outcome toward the run sequencer
	wire logic any_gating = |gating;

	// Jog is never gated; otherwise gating timers confine run to their interval
	wire logic run_nxt = jog_s ? run_s
		: any_gating ? (run_s & win_any)
		: run_s;                                          // see [RULE_04] [RULE_13]

	wire logic ovr_nxt  = win_any & ~jog_s;               // see [RULE_04]
	wire logic pi_nxt   = ovr_nxt & (win_act == SRTU_ACT_RUN_NOPI); // see [RULE_05]
	wire logic off_nxt  = run_s & any_gating & ~win_any & ~jog_s;  // see [RULE_17]
	wire logic [SRTU_NT-1:0] stat_nxt = active_r & ~cancel_r;      // see [RULE_08]

	// All results leave through flip-flops
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timer_status_out <= '0;
			run_enable_out   <= 1'b0;
			ref_override_out <= 1'b0;
			ref_source_out   <= '0;
			pi_disable_out   <= 1'b0;
			timers_off_out   <= 1'b0;
		end
		else
		begin
			timer_status_out <= stat_nxt;
			run_enable_out   <= run_nxt;
			ref_override_out <= ovr_nxt;
			ref_source_out   <= ovr_nxt ? win_ref : '0;
			pi_disable_out   <= pi_nxt;
			timers_off_out   <= off_nxt;
		end
	end

	// ==========================================================
	// Read path
	logic [31:0] status_word;

	// Status word mirrors the registered outputs and internal state
	always_comb
	begin
		status_word = '0;
		status_word[SRTU_S_ACTIVE +: SRTU_NT] = active_r;
		status_word[SRTU_S_CANCEL +: SRTU_NT] = cancel_r;
		status_word[SRTU_S_RUN]               = run_enable_out;
		status_word[SRTU_S_OFF]               = timers_off_out;
		status_word[SRTU_S_REF +: SRTU_REF_W] = ref_source_out;
		status_word[SRTU_S_PI]                = pi_disable_out;
		status_word[SRTU_S_WIN]               = ref_override_out;
	end

	logic [31:0] rd_mux;

	// Forward a write in its data phase to a read right behind it
	always_comb
	begin
		rd_mux = '0;
		for (int i = 0; i < SRTU_NT; i++)
		begin
			if (cfg_rsel[i])
				rd_mux = (cfg_wsel[i]) ? (hwdata & SRTU_CFG_MASK) : cfg_r[i];
		end
		if ((ap_addr == SRTU_OFF_STATUS) && !ap_upper)
			rd_mux = status_word;
	end

	// Read data captured at the address phase, shown in the data phase
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			hrdata_r <= '0;
		else if (ap_read)
			hrdata_r <= rd_mux;
	end

	// Zero wait states and OKAY on every transfer, mapped or not
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= SRTU_HRESP_OKAY[0];
		end
	end

	assign hrdata = hrdata_r;

endmodule

`default_nettype wire

//--- bench/srtu_top_checker.sv
// Purpose: port level checks for the scheduled run timer unit
// Assumes: pins pass a two stage synchroniser, outputs are registered
// Notes:   bound to srtu_top after the module
`timescale 1ns/1ps
`default_nettype none
module srtu_top_checker
	import srtu_pkg::*;
(
	input wire logic                          sys_clk,
	input wire logic                          rst_n,
	input wire logic                          hresp,
	input wire logic                          rtc_tick,
	input wire logic                          rtc_set,
	input wire logic                          run_cmd_in,
	input wire logic                          jog_fwd_in,
	input wire logic                          jog_rev_in,
	input wire logic                          timer_disable_in,
	input wire logic                          timer_cancel_in,
	input wire logic [srtu_pkg::SRTU_NT-1:0]    timer_status_out,
	input wire logic                          run_enable_out,
	input wire logic                          ref_override_out,
	input wire logic [srtu_pkg::SRTU_REF_W-1:0] ref_source_out,
	input wire logic                          pi_disable_out,
	input wire logic                          timers_off_out
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Pin levels held long enough to cross the synchroniser
	sequence s_jog;
		(jog_fwd_in || jog_rev_in) [*5];
	endsequence
	sequence s_dis_run;
		(timer_disable_in && run_cmd_in) [*5];
	endsequence
	sequence s_run_low;
		!run_cmd_in [*5];
	endsequence
	// ==========================================================
	// Output relations
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay)
		else $error("error response");
	property p_ref_zero;
		!ref_override_out |-> ref_source_out == 3'h0;
	endproperty
	a_ref_zero: assert property (p_ref_zero)
		else $error("ref code, no override");
	property p_pi_override;
		pi_disable_out |-> ref_override_out;
	endproperty
	a_pi_override: assert property (p_pi_override)
		else $error("PI off, no winner");
	property p_override_active;
		ref_override_out |-> timer_status_out != 4'h0;
	endproperty
	a_override_active: assert property (p_override_active)
		else $error("override, no active timer");
	property p_off_excl;
		timers_off_out |-> !ref_override_out && !pi_disable_out;
	endproperty
	a_off_excl: assert property (p_off_excl)
		else $error("timers off yet driving");
	property p_jog;
		s_jog |-> !ref_override_out && !pi_disable_out && !timers_off_out;
	endproperty
	a_jog: assert property (p_jog)
		else $error("timer acts in jog");
	property p_dis_run;
		s_dis_run |-> run_enable_out && !ref_override_out && !pi_disable_out;
	endproperty
	a_dis_run: assert property (p_dis_run)
		else $error("disabled timers gate run");
	property p_run_low;
		s_run_low |-> !run_enable_out && !timers_off_out;
	endproperty
	a_run_low: assert property (p_run_low)
		else $error("run without command");
	// Status moves only on an evaluation strobe or a run or cancel pin change
	property p_status_cause;
		$changed(timer_status_out) |-> $past(rtc_tick || rtc_set, 2)
			|| $past(run_cmd_in, 4) != $past(run_cmd_in, 5)
			|| $past(timer_cancel_in, 4) != $past(timer_cancel_in, 5)
			|| !$past(rst_n, 3);
	endproperty
	a_status_cause: assert property (p_status_cause)
		else $error("status change, no cause");
endmodule
bind srtu_top srtu_top_checker srtu_top_checker_i (.*);
`default_nettype wire

//--- bench/srtu_rtc_model.sv
// Purpose: real-time clock stand-in feeding time, weekday and strobes
// Assumes: the bench asks for a new time with a one-cycle request
// Notes:   time holds between requests like a real minute counter
`timescale 1ns/1ps
`default_nettype none
module srtu_rtc_model
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        req,
	input  wire logic        req_set,
	input  wire logic [10:0] req_min,
	input  wire logic [2:0]  req_wd,
	output logic [10:0]      rtc_minute,
	output logic [2:0]       rtc_weekday,
	output logic             rtc_tick,
	output logic             rtc_set
);
	// ==========================================================
	// New time appears with exactly one strobe cycle
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rtc_minute  <= 11'h000;
			rtc_weekday <= 3'h0;
			rtc_tick    <= 1'b0;
			rtc_set     <= 1'b0;
		end
		else
		begin
			rtc_tick <= req && !req_set;
			rtc_set  <= req && req_set;
			if (req)
			begin
				rtc_minute  <= req_min;
				rtc_weekday <= req_wd;
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/tb.sv
// Purpose: self-checking bench for the scheduled run timer unit
// Assumes: zero wait AHB slave, the rtc model supplies time strobes
// Notes:   random schedules come from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module tb;
	import srtu_pkg::*;
	logic        sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, req, req_set;
	logic [1:0]  htrans;
	logic [2:0]  hsize, rtc_weekday, req_wd, ref_source_out;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [10:0] rtc_minute, req_min;
	logic        rtc_tick, rtc_set, run_cmd_in, jog_fwd_in, jog_rev_in;
	logic        timer_disable_in, timer_cancel_in, run_enable_out, ref_override_out;
	logic        pi_disable_out, timers_off_out;
	logic [3:0]  timer_status_out;
	int          st[4], sp[4], dy[4], ac[4], rf[4], now, wd, k, n, bad_count, comparisons;
	bit          cx[4], run, jog, dis, can;
	int unsigned seed = 32'h0000_63B2;
	srtu_top srtu_top_i (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .rtc_minute, .rtc_weekday, .rtc_tick,
		.rtc_set, .run_cmd_in, .jog_fwd_in, .jog_rev_in, .timer_disable_in, .timer_cancel_in,
		.timer_status_out, .run_enable_out, .ref_override_out, .ref_source_out,
		.pi_disable_out, .timers_off_out);
	srtu_rtc_model srtu_rtc_model_i (.sys_clk, .rst_n, .req, .req_set, .req_min, .req_wd,
		.rtc_minute, .rtc_weekday, .rtc_tick, .rtc_set);
	// ==========================================================
	// Clock, random source, model and compares
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Schedule window model
	function automatic bit in_win(int i, int m, int w);
		bit d;
		d = dy[i] == 1 || (dy[i] == 2 && w < 5) || (dy[i] == 3 && w > 4) || dy[i] == w + 4;
		if (st[i] != sp[i])
			return d && m >= st[i] && m < sp[i];
		if (dy[i] == 2)
			return (w == 0 && m >= st[i]) || (w > 0 && w < 4) || (w == 4 && m < st[i]);
		if (dy[i] == 3)
			return (w == 5 && m >= st[i]) || (w == 6 && m < st[i]);
		return d && m >= st[i];
	endfunction
	function automatic logic [31:0] cw(int i);
		return 32'(st[i]) | 32'(sp[i]) << SRTU_F_STOP | 32'(dy[i]) << SRTU_F_DAY
			| 32'(ac[i]) << SRTU_F_ACT | 32'(rf[i]) << SRTU_F_REF;
	endfunction
	task automatic chk_reg(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch t=%0t register got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(logic [10:0] got, logic [10:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch t=%0t outputs got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_outs();
		logic [3:0] a;
		int         wn;
		bit         hit, gx, ov;
		wn = 0;
		hit = 0;
		gx = 0;
		for (int i = 3; i >= 0; i--)
		begin
			a[i] = in_win(i, now, wd) && !cx[i];
			gx |= ac[i] != 0;
			if (a[i] && ac[i] != 0)
			begin
				wn = i;
				hit = 1;
			end
		end
		ov = hit && !dis && !jog;
		chk_out({timer_status_out, run_enable_out, ref_override_out, ref_source_out,
			pi_disable_out, timers_off_out}, {a, run && (jog || dis || !gx || hit), ov,
			3'(ov ? rf[wn] : 0), ov && ac[wn] == 2, run && gx && !hit && !dis && !jog});
	endtask
	// ==========================================================
	// Bus master: each phase held until hready is seen high at an edge
	task automatic bus(logic [31:0] a, logic w, logic [31:0] d);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic cfg(int i, int s, int p, int d, int a, int r);
		st[i] = s;
		sp[i] = p;
		dy[i] = d;
		ac[i] = a;
		rf[i] = r;
		bus(32'(4 * i), 1'b1, cw(i));
	endtask
	task automatic rand_cfg(int i);
		int s, p, a;
		s = xs() % 1441;
		p = s + xs() % (1441 - s);
		a = xs() % 3;
		if (xs() % 4 == 0)
			p = (s % 1440);
		cfg(i, p == s % 1440 ? p : s, p, a != 0 ? 1 + xs() % 10 : xs() % 11, a, xs() % 7);
	endtask
	// New time from the clock model
	task automatic clock_to(int m, int w, bit s);
		@(posedge sys_clk);
		req     <= 1'b1;
		req_set <= s;
		req_min <= 11'(m);
		req_wd  <= 3'(w);
		@(posedge sys_clk);
		req <= 1'b0;
		repeat (5) @(posedge sys_clk);
		now = m;
		wd = w;
		foreach (cx[i])
			cx[i] = cx[i] && in_win(i, m, w);
	endtask
	// Results settle within four edges after a pin change
	task automatic pins(bit r, bit jf, bit jr, bit d, bit c);
		@(posedge sys_clk);
		run_cmd_in       <= r;
		jog_fwd_in       <= jf;
		jog_rev_in       <= jr;
		timer_disable_in <= d;
		timer_cancel_in  <= c;
		foreach (cx[i])
			cx[i] = (cx[i] || (c && !can && in_win(i, now, wd))) && !(r && !run);
		run = r;
		jog = jf || jr;
		dis = d;
		can = c;
		repeat (5) @(posedge sys_clk);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		{rst_n, hsel, hwrite, htrans, haddr, hwdata, req, req_set, req_min, req_wd} = '0;
		{run_cmd_in, jog_fwd_in, jog_rev_in, timer_disable_in, timer_cancel_in} = '0;
		hsize = 3'h2;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			bus(32'(4 * i), 1'b0, 32'h0);
			chk_reg(rd, 32'h0);
		end
		bus(32'h0000_0014, 1'b1, 32'hFFFF_FFFF);
		bus(32'h0000_0014, 1'b0, 32'h0);
		chk_reg(rd, 32'h0);
		pins(1, 0, 0, 0, 0);
		for (int t = 0; t < 8; t++)
		begin
			for (int i = 0; i < 4; i++)
				rand_cfg(i);
			for (int i = 0; i < 4; i++)
			begin
				bus(32'(4 * i), 1'b0, 32'h0);
				chk_reg(rd, cw(i));
			end
			for (int j = 0; j < 16; j++)
			begin
				k = j % 4;
				n = j < 4 ? st[k] : j < 8 ? sp[k] - 1 : j < 12 ? sp[k] : xs() % 1440;
				clock_to(n < 0 ? 0 : n > 1439 ? 1439 : n, xs() % 7, j % 5 == 0);
				check_outs();
			end
		end
		cfg(0, 600, 700, 1, 1, 5);
		for (int i = 1; i < 4; i++)
			cfg(i, 0, 0, 0, 0, 0);
		clock_to(650, 2, 1);
		check_outs();
		pins(1, 0, 0, 0, 1);
		check_outs();
		pins(0, 0, 0, 0, 0);
		pins(1, 0, 0, 0, 0);
		check_outs();
		pins(1, 0, 0, 1, 0);
		check_outs();
		pins(1, 1, 0, 0, 0);
		check_outs();
		pins(1, 0, 1, 0, 0);
		check_outs();
		pins(1, 0, 0, 0, 0);
		clock_to(700, 2, 0);
		check_outs();
		complete_run();
	end
	// Watchdog well past the run's length
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		$display("mismatch t=%0t watchdog expired", $time);
		complete_run();
	end
endmodule
`default_nettype wire
